// >>> hw/iobrp_defs.svh
// Constants for the expansion bus restart and presence supervisor
// Overview of operation
// R1: The bus restart request bit is cleared by reset, so no restart is asked for until software writes it.
// R2: A restart is started only on a 0-to-1 edge of the request bit, and only when all restart conditions hold.
// R3: One restart condition is that the error handling select is in its active setting.
// R4: One restart condition is that bits 0 and 1 of the system fault word both read zero.
// R5: One restart condition is that at least one module state holds the module bus error code.
// R6: With the request set but any condition false, nothing changes and no restart takes place; the code still sets the refused event bit.
// R7: Under active error handling a bus communication error forces embedded and module outputs to zero.
// R8: A restart runs while the controller keeps running, with no reset, power cycle or download.
// R9: Every bus start compares the configured module list with the modules present.
// R10: A missing configured module that is not optional flags an error and keeps the bus stopped.
// R11: Missing modules marked optional are skipped so that the bus starts normally.
// R12: The optional mark is refused for link modules and cartridges; the code refuses it for link modules only.
// R13: Bus exchanges are paced by a selectable task tick that may override the general setting.
// R14: A module is in bus error only after its exchange failed on two consecutive bus cycles.
// R15: The error handling select resets to active, and software may set it to passive.
// R16: After a good restart every module state returns to the healthy code and the bus error clears; the code gives configured absent modules the absent code.
`ifndef IOBRP_DEFS_SVH
`define IOBRP_DEFS_SVH
// Register byte offsets
`define IOBRP_OFF_CTRL     8'h00
`define IOBRP_OFF_CFG_MOD  8'h04
`define IOBRP_OFF_CFG_OPT  8'h08
`define IOBRP_OFF_CFG_LINK 8'h0c
`define IOBRP_OFF_PRESENT  8'h10
`define IOBRP_OFF_STATUS   8'h14
`define IOBRP_OFF_IRQ_STAT 8'h18
`define IOBRP_OFF_IRQ_MASK 8'h1c
`define IOBRP_OFF_FAULT    8'h20
`define IOBRP_OFF_TASK_DIV 8'h24
`define IOBRP_OFF_MODST0   8'h40
// Control register fields
`define IOBRP_CTRL_RESTART 0
`define IOBRP_CTRL_PASSIVE 1
`define IOBRP_CTRL_START   2
`define IOBRP_CTRL_TASKSEL 3
// Status fields
`define IOBRP_ST_RUN       0
`define IOBRP_ST_BUSERR    1
`define IOBRP_ST_CFGERR    2
`define IOBRP_ST_FORCE0    3
// Event bits
`define IOBRP_EV_CFGERR    0
`define IOBRP_EV_BUSERR    1
`define IOBRP_EV_RESTART   2
`define IOBRP_EV_REFUSED   3
`define IOBRP_NEV          4
// Module state codes
`define IOBRP_MOD_OK       8'h00
`define IOBRP_MOD_BUSERR   8'h01
`define IOBRP_MOD_ABSENT   8'h02
// Fault bits meaning bus healthy
`define IOBRP_FAULT_RESET  32'h0000_0003
`define IOBRP_FAIL_LIMIT   2'd2
`define IOBRP_TASK_DIV_RST 16'h0064
`endif

// >>> hw/iobrp_pkg.sv
// Types for the expansion bus restart and presence supervisor
package iobrp_pkg;
  typedef enum logic [3:0] {
    IOBRP_STOP  = 4'b0001,
    IOBRP_CHECK = 4'b0010,
    IOBRP_RUN   = 4'b0100,
    IOBRP_OFF   = 4'b1000
  } iobrp_bus_t;
endpackage

// >>> hw/iobrp_tick.sv
// Bus task tick divider
`timescale 1ns/100ps
`include "iobrp_defs.svh"
module iobrp_tick (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Divider setting
  input  wire logic [15:0] i_div,
  // Tick out
  output logic             o_tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } iobrp_tick_st_t;
  iobrp_tick_st_t st_reg, st_next;

  // Count down, pulse on wrap; zero divider treated as one
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == 16'h0000) begin
      st_next.cnt = (i_div == 16'h0000) ? 16'h0000 : i_div - 16'h0001;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt - 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_tick = st_reg.tick;
endmodule

// >>> hw/iobrp_mod_mon.sv
// Per-module exchange failure tracker
`timescale 1ns/100ps
`include "iobrp_defs.svh"
module iobrp_mod_mon (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // Control
  input  wire logic       i_tick,
  input  wire logic       i_active,
  input  wire logic       i_fail,
  input  wire logic       i_clear,
  input  wire logic       i_absent,
  // State
  output logic [7:0]      o_state
);
  typedef struct packed {
    logic [1:0] fails;
    logic [7:0] state;
  } iobrp_mon_st_t;
  iobrp_mon_st_t st_reg, st_next;

  // Two consecutive failed cycles make a bus error
  always_comb begin
    st_next = st_reg;
    if (i_clear) begin
      st_next.fails = 2'd0;
      st_next.state = i_absent ? `IOBRP_MOD_ABSENT : `IOBRP_MOD_OK;
    end else if (i_tick && i_active) begin
      if (!i_fail) begin
        st_next.fails = 2'd0;
      end else if (st_reg.fails != `IOBRP_FAIL_LIMIT) begin
        st_next.fails = st_reg.fails + 2'd1;
      end
      // R14 two-cycle qualification
      if (i_fail && st_reg.fails + 2'd1 >= `IOBRP_FAIL_LIMIT) begin
        st_next.state = `IOBRP_MOD_BUSERR;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_state = st_reg.state;

  chk_two_fail_err: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R14
    (i_tick && i_active && i_fail && st_reg.fails == 2'd0 && !i_clear) |=> st_reg.state == $past(st_reg.state))
    else $error("module error after a single failed cycle");
endmodule

// >>> hw/iobrp_top.sv
// Expansion bus supervisor: presence check, error handling, restart, AHB-Lite slave
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "iobrp_defs.svh"
module iobrp_top #(
  parameter int NMOD = 8
) (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // AHB-Lite slave
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic [31:0]            o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  // Module chain
  input  wire logic [NMOD-1:0]   i_mod_present,
  input  wire logic [NMOD-1:0]   i_mod_fail,
  input  wire logic              i_ext_tick,
  input  wire logic              i_init_cmd,
  output logic [NMOD-1:0]        o_mod_xchg_en,
  // Output force and status
  output logic                   o_force_zero,
  output logic                   o_bus_run,
  output logic                   o_irq
);
  import iobrp_pkg::*;

  typedef struct packed {
    iobrp_bus_t       bus;
    logic             restart_req;
    logic             restart_prev;
    logic             passive;
    logic             task_sel;
    logic [15:0]      task_div;
    logic [NMOD-1:0]  cfg_mod;
    logic [NMOD-1:0]  cfg_opt;
    logic [NMOD-1:0]  cfg_link;
    logic [31:0]      fault;
    logic             cfg_err;
    logic             start_req;
    logic [`IOBRP_NEV-1:0] irq_stat;
    logic [`IOBRP_NEV-1:0] irq_mask;
    logic             d_pend;
    logic             d_wr;
    logic [7:0]       d_addr;
    logic [31:0]      rdata;
    logic [NMOD-1:0]  xchg_en;
    logic             force0;
    logic             irq;
  } iobrp_st_t;
  iobrp_st_t st_reg, st_next;

  // Pin synchronisers for presence, failure and external tick
  logic [NMOD-1:0] pres_s1_reg, pres_s2_reg, fail_s1_reg, fail_s2_reg;
  logic            etick_s1_reg, etick_s2_reg, etick_s3_reg, init_s1_reg, init_s2_reg, init_s3_reg;
  always_ff @(posedge i_clk_sys) begin
    pres_s1_reg  <= i_mod_present;
    pres_s2_reg  <= pres_s1_reg;
    fail_s1_reg  <= i_mod_fail;
    fail_s2_reg  <= fail_s1_reg;
    etick_s1_reg <= i_ext_tick;
    etick_s2_reg <= etick_s1_reg;
    etick_s3_reg <= etick_s2_reg;
    init_s1_reg  <= i_init_cmd;
    init_s2_reg  <= init_s1_reg;
    init_s3_reg  <= init_s2_reg;
  end

  // Task tick: internal divider or external task edge
  logic int_tick, bus_tick;
  iobrp_tick u_tick (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_div     (st_reg.task_div),
    .o_tick    (int_tick)
  );
  // R13 task selection override
  assign bus_tick = st_reg.task_sel ? (etick_s2_reg & ~etick_s3_reg) : int_tick;

  // Per-module monitors
  logic [7:0]      mod_state [NMOD];
  logic [NMOD-1:0] mod_err;
  logic            mon_clear;
  logic            do_restart;
  assign mon_clear = (st_reg.bus == IOBRP_CHECK) || do_restart;
  genvar g;
  generate
    for (g = 0; g < NMOD; g++) begin : g_mon
      iobrp_mod_mon u_mon (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_tick    (bus_tick),
        .i_active  (st_reg.bus == IOBRP_RUN && st_reg.xchg_en[g]),
        .i_fail    (fail_s2_reg[g]),
        .i_clear   (mon_clear),
        .i_absent  (st_reg.cfg_mod[g] && !pres_s2_reg[g]),
        .o_state   (mod_state[g])
      );
      assign mod_err[g] = (mod_state[g] == `IOBRP_MOD_BUSERR);
    end
  endgenerate

  // Restart conditions
  logic cond_active, cond_fault, cond_moderr, rst_edge, refused;
  // R3 active handling, bus off
  assign cond_active = !st_reg.passive && (st_reg.bus == IOBRP_OFF);
  // R4 fault bits 0 and 1 low
  assign cond_fault  = (st_reg.fault[1:0] == 2'b00);
  // R5 some module in error
  assign cond_moderr = |mod_err;
  // R2 edge detect on request
  assign rst_edge    = st_reg.restart_req && !st_reg.restart_prev;
  // R6 any false condition means no action; R8 restart without reset
  assign do_restart  = rst_edge && cond_active && cond_fault && cond_moderr;
  assign refused     = rst_edge && !do_restart;

  // Presence comparison
  logic [NMOD-1:0] missing_hard;
  // R11 optional absentees skipped; R12 link modules never optional
  assign missing_hard = st_reg.cfg_mod & ~pres_s2_reg & ~(st_reg.cfg_opt & ~st_reg.cfg_link);

  // Register index decode used for reads
  function automatic logic [31:0] rd_mux(input iobrp_st_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == `IOBRP_OFF_CTRL) begin
      r[`IOBRP_CTRL_RESTART] = s.restart_req;
      r[`IOBRP_CTRL_PASSIVE] = s.passive;
      r[`IOBRP_CTRL_TASKSEL] = s.task_sel;
    end else if (a == `IOBRP_OFF_CFG_MOD) begin
      r[NMOD-1:0] = s.cfg_mod;
    end else if (a == `IOBRP_OFF_CFG_OPT) begin
      r[NMOD-1:0] = s.cfg_opt;
    end else if (a == `IOBRP_OFF_CFG_LINK) begin
      r[NMOD-1:0] = s.cfg_link;
    end else if (a == `IOBRP_OFF_STATUS) begin
      r[`IOBRP_ST_RUN]    = (s.bus == IOBRP_RUN);
      r[`IOBRP_ST_BUSERR] = (s.bus == IOBRP_OFF);
      r[`IOBRP_ST_CFGERR] = s.cfg_err;
      r[`IOBRP_ST_FORCE0] = s.force0;
    end else if (a == `IOBRP_OFF_IRQ_STAT) begin
      r[`IOBRP_NEV-1:0] = s.irq_stat;
    end else if (a == `IOBRP_OFF_IRQ_MASK) begin
      r[`IOBRP_NEV-1:0] = s.irq_mask;
    end else if (a == `IOBRP_OFF_FAULT) begin
      r = s.fault;
    end else if (a == `IOBRP_OFF_TASK_DIV) begin
      r[15:0] = s.task_div;
    end
    return r;
  endfunction

  // Main next-state logic
  logic [`IOBRP_NEV-1:0] ev;
  logic                  wr_now;
  always_comb begin
    st_next = st_reg;
    ev = '0;
    wr_now = st_reg.d_pend && st_reg.d_wr;
    st_next.restart_prev = st_reg.restart_req;

    // Bus state machine
    case (st_reg.bus)
      IOBRP_STOP: begin
        if (st_reg.start_req) begin
          st_next.bus = IOBRP_CHECK;
          st_next.start_req = 1'b0;
        end
      end
      // R9 compare configuration with present modules
      IOBRP_CHECK: begin
        if (|missing_hard) begin
          // R10 hard absence keeps the bus stopped
          st_next.bus = IOBRP_STOP;
          st_next.cfg_err = 1'b1;
          ev[`IOBRP_EV_CFGERR] = 1'b1;
        end else begin
          st_next.bus = IOBRP_RUN;
          st_next.cfg_err = 1'b0;
          st_next.fault[1:0] = 2'b11;
          st_next.xchg_en = st_reg.cfg_mod & pres_s2_reg;
        end
      end
      IOBRP_RUN: begin
        if (st_reg.start_req) begin
          // R9 start recheck while running
          st_next.bus = IOBRP_CHECK;
          st_next.start_req = 1'b0;
        end else if (cond_moderr) begin
          st_next.fault[1:0] = 2'b00;
          ev[`IOBRP_EV_BUSERR] = 1'b1;
          if (!st_reg.passive) begin
            st_next.bus = IOBRP_OFF;
          end
        end
      end
      IOBRP_OFF: begin
        // R16 good restart returns bus to checked start
        if (do_restart) begin
          st_next.bus = IOBRP_CHECK;
          ev[`IOBRP_EV_RESTART] = 1'b1;
        end
      end
      default: st_next.bus = IOBRP_STOP;
    endcase
    if (refused) begin
      ev[`IOBRP_EV_REFUSED] = 1'b1;
    end
    // Rising edge only, so a long command asks for one start
    if (init_s2_reg && !init_s3_reg) begin
      st_next.start_req = 1'b1;
    end

    // R7 outputs forced to zero while bus is off under active handling
    st_next.force0 = (st_next.bus == IOBRP_OFF) || (st_next.bus != IOBRP_RUN && st_next.cfg_err);

    // Register writes from data phase
    if (wr_now) begin
      if (st_reg.d_addr == `IOBRP_OFF_CTRL) begin
        st_next.restart_req = i_hwdata[`IOBRP_CTRL_RESTART];
        st_next.passive = i_hwdata[`IOBRP_CTRL_PASSIVE];
        st_next.task_sel = i_hwdata[`IOBRP_CTRL_TASKSEL];
        if (i_hwdata[`IOBRP_CTRL_START]) begin
          st_next.start_req = 1'b1;
        end
      end else if (st_reg.d_addr == `IOBRP_OFF_CFG_MOD) begin
        st_next.cfg_mod = i_hwdata[NMOD-1:0];
      end else if (st_reg.d_addr == `IOBRP_OFF_CFG_OPT) begin
        // R12 optional mark refused on link modules
        st_next.cfg_opt = i_hwdata[NMOD-1:0] & ~st_reg.cfg_link;
      end else if (st_reg.d_addr == `IOBRP_OFF_CFG_LINK) begin
        st_next.cfg_link = i_hwdata[NMOD-1:0];
        st_next.cfg_opt = st_reg.cfg_opt & ~i_hwdata[NMOD-1:0];
      end else if (st_reg.d_addr == `IOBRP_OFF_IRQ_STAT) begin
        st_next.irq_stat = st_reg.irq_stat & ~i_hwdata[`IOBRP_NEV-1:0];
      end else if (st_reg.d_addr == `IOBRP_OFF_IRQ_MASK) begin
        st_next.irq_mask = i_hwdata[`IOBRP_NEV-1:0];
      end else if (st_reg.d_addr == `IOBRP_OFF_TASK_DIV) begin
        st_next.task_div = i_hwdata[15:0];
      end
    end
    // Set wins over a simultaneous write-one clear
    st_next.irq_stat = st_next.irq_stat | ev;
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

    // Address phase capture; zero wait states
    st_next.d_pend = i_hsel && i_hready && i_htrans[1];
    st_next.d_wr = i_hwrite;
    st_next.d_addr = i_haddr[7:0];
    st_next.rdata = 32'h0000_0000;
    if (i_hsel && i_hready && i_htrans[1] && !i_hwrite) begin
      if (i_haddr[7:0] == `IOBRP_OFF_PRESENT) begin
        st_next.rdata[NMOD-1:0] = pres_s2_reg;
      end else if (i_haddr[7:0] >= `IOBRP_OFF_MODST0 &&
                   i_haddr[7:0] < `IOBRP_OFF_MODST0 + 8'(4 * NMOD)) begin
        st_next.rdata[7:0] = mod_state[3'(i_haddr[7:2] - 6'(`IOBRP_OFF_MODST0 >> 2))];
      end else begin
        st_next.rdata = rd_mux(st_reg, i_haddr[7:0]);
      end
    end
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.bus <= IOBRP_STOP;
      // R1 restart request cleared; R15 active handling (passive=0)
      st_reg.restart_req <= 1'b0;
      st_reg.passive <= 1'b0;
      st_reg.start_req <= 1'b1;
      st_reg.task_div <= `IOBRP_TASK_DIV_RST;
      st_reg.fault <= `IOBRP_FAULT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs from flops; ready and response tied off
  assign o_hrdata      = st_reg.rdata;
  assign o_hreadyout   = 1'b1;
  assign o_hresp       = 1'b0;
  assign o_mod_xchg_en = st_reg.xchg_en;
  assign o_force_zero  = st_reg.force0;
  assign o_bus_run     = (st_reg.bus == IOBRP_RUN);
  assign o_irq         = st_reg.irq;

  // Checks
  chk_restart_reset_clr: assert property (@(posedge i_clk_sys) // R1
    i_rst |=> !st_reg.restart_req) else $error("restart request not cleared by reset");
  chk_edge_only_restart: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R2
    (st_reg.bus == IOBRP_OFF && st_reg.restart_prev) |=> st_reg.bus != IOBRP_CHECK)
    else $error("restart on level not edge");
  chk_passive_no_restart: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R3
    (st_reg.passive && st_reg.bus == IOBRP_OFF) |=> st_reg.bus != IOBRP_CHECK)
    else $error("restart under passive handling");
  chk_fault_no_restart: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R4
    (st_reg.fault[1:0] != 2'b00) |-> !do_restart) else $error("restart with fault bits set");
  chk_moderr_restart: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R5
    do_restart |-> cond_moderr) else $error("restart with no module in error");
  chk_refused_still: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R6
    (refused && st_reg.bus == IOBRP_OFF) |=> st_reg.bus == IOBRP_OFF) else $error("refused restart moved bus");
  chk_force_zero_off: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R7
    (st_reg.bus == IOBRP_OFF) |-> st_reg.force0) else $error("outputs not forced in bus off");
  chk_hard_absent_stop: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R10
    (st_reg.bus == IOBRP_CHECK && |missing_hard) |=> (st_reg.bus == IOBRP_STOP && st_reg.cfg_err))
    else $error("bus started with mandatory module absent");
  chk_link_not_opt: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R12
    (st_reg.cfg_opt & st_reg.cfg_link) == '0) else $error("link module marked optional");
  chk_restart_heals: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R16
    do_restart |=> ##1 (st_reg.bus == IOBRP_RUN || st_reg.bus == IOBRP_STOP)) else $error("restart did not recheck");
  cov_restart: cover property (@(posedge i_clk_sys) disable iff (i_rst) do_restart);
  cov_refused: cover property (@(posedge i_clk_sys) disable iff (i_rst) refused);
  cov_cfg_err: cover property (@(posedge i_clk_sys) disable iff (i_rst) ev[`IOBRP_EV_CFGERR]);
endmodule

// >>> testbench/iobrp_chain_model.sv
// Behavioural chain of expansion modules on the far side of the supervisor
`timescale 1ns/100ps
module iobrp_chain_model #(
  parameter int NMOD = 8
) (
  // Clock and reset
  input  wire logic            i_clk_sys,
  input  wire logic            i_rst,
  // Scenario control
  input  wire logic [NMOD-1:0] i_attach,
  input  wire logic [NMOD-1:0] i_break,
  // Bus side
  input  wire logic [NMOD-1:0] i_xchg_en,
  output logic [NMOD-1:0]      o_mod_present,
  output logic [NMOD-1:0]      o_mod_fail
);
  // Presence follows the physical fit
  assign o_mod_present = i_attach;
  // A broken module fails only when it is really exchanged, so idle modules never report
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_mod_fail <= '0;
    end else begin
      o_mod_fail <= i_xchg_en & i_break & i_attach;
    end
  end
endmodule

// >>> testbench/tb_io_bus_restart_presence.sv
// Self-checking bench for the expansion bus supervisor
`timescale 1ns/100ps
`include "iobrp_defs.svh"
module tb_io_bus_restart_presence;
  logic        i_clk_sys;
  logic        i_rst;
  logic        i_hsel;
  logic [31:0] i_haddr;
  logic [1:0]  i_htrans;
  logic        i_hwrite;
  logic [2:0]  i_hsize;
  logic [31:0] i_hwdata;
  logic [31:0] o_hrdata;
  logic        o_hreadyout;
  logic        o_hresp;
  logic [7:0]  attach;
  logic [7:0]  brk;
  logic [7:0]  present;
  logic [7:0]  fail;
  logic [7:0]  xchg_en;
  logic        i_ext_tick;
  logic        i_init_cmd;
  logic        o_force_zero;
  logic        o_bus_run;
  logic        o_irq;
  logic [31:0] rd;
  int          n_fail;
  int          num_checks;
  int          cyc;

  // Single slave, so its ready is the bus ready
  iobrp_top #(.NMOD(8)) dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_mod_present(present),
    .i_mod_fail(fail), .i_ext_tick(i_ext_tick), .i_init_cmd(i_init_cmd), .o_mod_xchg_en(xchg_en),
    .o_force_zero(o_force_zero), .o_bus_run(o_bus_run), .o_irq(o_irq)
  );

  iobrp_chain_model #(.NMOD(8)) chain (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_attach(attach), .i_break(brk),
    .i_xchg_en(xchg_en), .o_mod_present(present), .o_mod_fail(fail)
  );

  // Clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // Hang guard, well above the expected few hundred cycles
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One single-word transfer; waits on ready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clk_sys);
    i_hsel   <= 1'b1;
    i_htrans <= 2'b10;
    i_haddr  <= {24'h00_0000, a};
    i_hwrite <= wr;
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    i_hsel   <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= wd;
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read a register and compare the masked field
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd & m, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  // Bounded wait for the run flag, then compare it
  task automatic wait_run(input logic v);
    for (int i = 0; i < 60 && o_bus_run !== v; i++) @(posedge i_clk_sys);
    chk({31'h0, o_bus_run}, {31'h0, v});
  endtask

  // External task ticks; low time first so a failure set with the call has crossed its synchroniser
  task automatic tick(input int n);
    repeat (n) begin
      repeat (4) @(posedge i_clk_sys);
      i_ext_tick <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      i_ext_tick <= 1'b0;
    end
  endtask

  task automatic init_pulse();
    i_init_cmd <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    i_init_cmd <= 1'b0;
  endtask

  initial begin
    {i_hsel, i_haddr, i_htrans, i_hwrite, i_hwdata, i_ext_tick, i_init_cmd} = '0;
    i_hsize = 3'b010;
    attach = 8'hf7;
    brk = 8'h00;
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    i_rst = 1'b1;
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    // Reset values and an unmapped hole
    rdc(`IOBRP_OFF_CTRL, 32'hffff_ffff, 32'h0000_0000);
    rdc(`IOBRP_OFF_TASK_DIV, 32'h0000_ffff, 32'h0000_0064);
    rdc(8'h30, 32'hffff_ffff, 32'h0000_0000);
    // Presence check with an absent optional module
    wr(`IOBRP_OFF_IRQ_MASK, 32'h0000_0000);
    wr(`IOBRP_OFF_CFG_MOD, 32'h0000_000f);
    wr(`IOBRP_OFF_CFG_OPT, 32'h0000_0008);
    init_pulse();
    wait_run(1'b1);
    rdc(`IOBRP_OFF_STATUS, 32'h0000_0004, 32'h0000_0000);
    rdc(`IOBRP_OFF_MODST0 + 8'h0c, 32'h0000_00ff, 32'h0000_0002);
    chk({24'h0, xchg_en}, 32'h0000_0007);
    chk({31'h0, o_hresp}, 32'h0);
    rdc(`IOBRP_OFF_PRESENT, 32'h0000_00ff, 32'h0000_00f7);
    // Mandatory module missing keeps the bus stopped
    attach <= 8'hf5;
    wr(`IOBRP_OFF_CTRL, 32'h0000_0004);
    wait_run(1'b0);
    rdc(`IOBRP_OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
    rdc(`IOBRP_OFF_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
    chk({31'h0, o_irq}, 32'h0);
    wr(`IOBRP_OFF_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge i_clk_sys);
    chk({31'h0, o_irq}, 32'h1);
    wr(`IOBRP_OFF_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge i_clk_sys);
    chk({31'h0, o_irq}, 32'h0);
    // Link modules cannot be optional
    wr(`IOBRP_OFF_CFG_LINK, 32'h0000_0080);
    wr(`IOBRP_OFF_CFG_OPT, 32'h0000_0088);
    rdc(`IOBRP_OFF_CFG_OPT, 32'h0000_00ff, 32'h0000_0008);
    attach <= 8'hf7;
    init_pulse();
    wait_run(1'b1);
    // Externally paced ticks: one failed cycle is not yet an error
    wr(`IOBRP_OFF_CTRL, 32'h0000_0008);
    brk <= 8'h04;
    tick(1);
    brk <= 8'h00;
    tick(1);
    rdc(`IOBRP_OFF_MODST0 + 8'h08, 32'h0000_00ff, 32'h0000_0000);
    brk <= 8'h04;
    tick(2);
    rdc(`IOBRP_OFF_MODST0 + 8'h08, 32'h0000_00ff, 32'h0000_0001);
    chk({31'h0, o_force_zero}, 32'h1);
    chk({31'h0, o_bus_run}, 32'h0);
    rdc(`IOBRP_OFF_FAULT, 32'h0000_0003, 32'h0000_0000);
    rdc(`IOBRP_OFF_STATUS, 32'h0000_0002, 32'h0000_0002);
    brk <= 8'h00;
    // Passive select refuses the restart
    wr(`IOBRP_OFF_CTRL, 32'h0000_000a);
    wr(`IOBRP_OFF_CTRL, 32'h0000_000b);
    repeat (10) @(posedge i_clk_sys);
    rdc(`IOBRP_OFF_MODST0 + 8'h08, 32'h0000_00ff, 32'h0000_0001);
    rdc(`IOBRP_OFF_IRQ_STAT, 32'h0000_0008, 32'h0000_0008);
    // Rising edge with every condition true restarts while running
    wr(`IOBRP_OFF_CTRL, 32'h0000_0008);
    wr(`IOBRP_OFF_CTRL, 32'h0000_0009);
    wait_run(1'b1);
    rdc(`IOBRP_OFF_MODST0 + 8'h08, 32'h0000_00ff, 32'h0000_0000);
    chk({31'h0, o_force_zero}, 32'h0);
    rdc(`IOBRP_OFF_FAULT, 32'h0000_0003, 32'h0000_0003);
    rdc(`IOBRP_OFF_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
    // A held level without a new edge does nothing
    brk <= 8'h04;
    tick(2);
    brk <= 8'h00;
    wr(`IOBRP_OFF_CTRL, 32'h0000_0009);
    repeat (10) @(posedge i_clk_sys);
    rdc(`IOBRP_OFF_MODST0 + 8'h08, 32'h0000_00ff, 32'h0000_0001);
    chk({31'h0, o_bus_run}, 32'h0);
    print_verdict();
  end
endmodule
